/* File: design/tswi_pkg.sv */
package tswi_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  // short enough for the bench to cross many times, long enough for pedal bounce
  localparam int unsigned DEBOUNCE_US     = 100;
  localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DB_W            = 16;
  localparam logic [DB_W-1:0] DB_LIMIT    = DB_W'(DEBOUNCE_CYC - 1);

  localparam int unsigned TIME_W          = 16;
  localparam int unsigned SCHED_W         = 7;
  localparam logic [SCHED_W-1:0] SCHED_MAX = 7'h63;
  localparam logic [SCHED_W-1:0] SCHED_A_SINGLE = 7'h00;
  localparam logic [SCHED_W-1:0] SCHED_B  = 7'h14;
  localparam logic [SCHED_W-1:0] SCHED_C  = 7'h28;
  localparam logic [SCHED_W-1:0] SCHED_D  = 7'h3C;

  localparam int unsigned N_SW            = 4;
  localparam int unsigned VALVE_W         = 3;

  localparam logic [5:0]  PI_SECOND_STAGE = 6'h09;
  localparam logic [3:0]  FUNC_SECOND_STAGE = 4'h1;
  localparam logic        SRC_LOCAL       = 1'b0;

  localparam logic [31:0] OFF_CTRL        = 32'h0000_0000;
  localparam logic [31:0] OFF_TIMES       = 32'h0000_0004;
  localparam logic [31:0] OFF_VALVES      = 32'h0000_0008;
  localparam logic [31:0] OFF_STATUS      = 32'h0000_000C;

  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] TIMES_RESET     = 32'h0000_0000;
  localparam logic [31:0] VALVES_RESET    = 32'h0000_0000;

  // ctrl field positions
  localparam int unsigned CTRL_MULTI      = 0;
  localparam int unsigned CTRL_REPEAT     = 1;
  localparam int unsigned CTRL_EXT_SEL    = 2;
  localparam int unsigned CTRL_SRC        = 3;
  localparam int unsigned CTRL_FUNC_LSB   = 4;
  localparam int unsigned CTRL_PIN_LSB    = 8;
  localparam int unsigned CTRL_USE_LSB    = 16;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PRESQ   = 3'b001,
    ST_SQUEEZE = 3'b011,
    ST_WAIT2   = 3'b010,
    ST_PCHECK  = 3'b110,
    ST_WELD    = 3'b111,
    ST_HOLD    = 3'b101
  } tswi_state_t;

endpackage : tswi_pkg

/* File: design/tswi_top.sv */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tswi_top
  import tswi_pkg::*;
(
  input  wire logic                 clock_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [31:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire logic [N_SW-1:0]      foot_first_stage_contacts_in,
  input  wire logic                 programmable_input_nine_in,
  input  wire logic                 pressure_switch_input_in,
  input  wire logic [SCHED_W-1:0]   ext_schedule_select_in,
  input  wire logic                 weld_done_in,
  output logic [N_SW*VALVE_W-1:0]   valves_out,
  output logic                      weld_start_out,
  output logic [SCHED_W-1:0]        schedule_out
);

  typedef struct packed {
    logic [N_SW:0]                 sync1;
    logic [N_SW:0]                 sync2;
    logic [N_SW:0][DB_W-1:0]       db_cnt;
    logic [N_SW:0]                 clean;
    logic [31:0]                   ctrl;
    logic [31:0]                   times;
    logic [31:0]                   valve_map;
    tswi_state_t                   state;
    logic [TIME_W-1:0]             timer;
    logic [1:0]                    sw_idx;
    logic [VALVE_W-1:0]            valves;
    logic [SCHED_W-1:0]            sched;
    logic                          start;
    logic [31:0]                   rdata;
  } tswi_regs_t;

  tswi_regs_t r_q;
  tswi_regs_t r_d;

  logic                 access;
  logic                 mapped_ok;
  logic                 second_stage;
  logic                 first_any;
  logic                 first_held;
  logic [1:0]           first_idx;
  logic [SCHED_W-1:0]   sched_pick;
  logic [SCHED_W-1:0]   sched_a;
  logic [N_SW:0]        raw;

  assign access      = psel_in && penable_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !(paddr_in == OFF_CTRL || paddr_in == OFF_TIMES
                                   || paddr_in == OFF_VALVES || paddr_in == OFF_STATUS);

  assign raw = {programmable_input_nine_in, foot_first_stage_contacts_in};

  // second stage only counts through input nine mapped as local second-stage function
  assign mapped_ok = (r_q.ctrl[CTRL_PIN_LSB +: 6] == PI_SECOND_STAGE)
                   && (r_q.ctrl[CTRL_FUNC_LSB +: 4] == FUNC_SECOND_STAGE)
                   && (r_q.ctrl[CTRL_SRC] == SRC_LOCAL);
  assign second_stage = mapped_ok && r_q.clean[N_SW];

  assign first_any  = |r_q.clean[N_SW-1:0];
  assign first_held = r_q.clean[r_q.sw_idx];

  // lowest numbered switch wins when several close together
  always_comb begin
    first_idx = 2'h0;
    for (int i = N_SW - 1; i >= 0; i--) begin
      if (r_q.clean[i]) begin
        first_idx = 2'(i);
      end
    end
  end

  always_comb begin
    sched_a = r_q.ctrl[CTRL_EXT_SEL] ? ext_schedule_select_in
                                     : r_q.ctrl[CTRL_USE_LSB +: SCHED_W];
    if (sched_a > SCHED_MAX) begin
      sched_a = SCHED_MAX;
    end
    if (!r_q.ctrl[CTRL_MULTI]) begin
      sched_pick = SCHED_A_SINGLE;
    end else begin
      case (first_idx)
        2'h1:    sched_pick = SCHED_B;
        2'h2:    sched_pick = SCHED_C;
        2'h3:    sched_pick = SCHED_D;
        default: sched_pick = sched_a;
      endcase
    end
  end

  always_comb begin
    r_d       = r_q;
    r_d.start = 1'b0;
    r_d.sync1 = raw;
    r_d.sync2 = r_q.sync1;

    // a level must stay for the whole window before it is believed
    for (int i = 0; i <= N_SW; i++) begin
      if (r_q.sync2[i] == r_q.clean[i]) begin
        r_d.db_cnt[i] = '0;
      end else if (r_q.db_cnt[i] == DB_LIMIT) begin
        r_d.db_cnt[i] = '0;
        r_d.clean[i]  = r_q.sync2[i];
      end else begin
        r_d.db_cnt[i] = r_q.db_cnt[i] + 1'b1;
      end
    end

    if (psel_in && !penable_in && !pwrite_in) begin
      if (paddr_in == OFF_CTRL) begin
        r_d.rdata = r_q.ctrl;
      end else if (paddr_in == OFF_TIMES) begin
        r_d.rdata = r_q.times;
      end else if (paddr_in == OFF_VALVES) begin
        r_d.rdata = r_q.valve_map;
      end else if (paddr_in == OFF_STATUS) begin
        r_d.rdata = {9'h000, r_q.sched, 3'h0, r_q.clean, 2'h0, r_q.sw_idx, 1'b0, r_q.state};
      end else begin
        r_d.rdata = '0;
      end
    end
    if (access && pwrite_in) begin
      if (paddr_in == OFF_CTRL) begin
        r_d.ctrl = pwdata_in;
      end else if (paddr_in == OFF_TIMES) begin
        r_d.times = pwdata_in;
      end else if (paddr_in == OFF_VALVES) begin
        r_d.valve_map = pwdata_in;
      end
    end

    case (r_q.state)
      ST_IDLE: begin
        r_d.valves = '0;
        if (first_any) begin
          r_d.sw_idx = first_idx;
          r_d.sched  = sched_pick;
          r_d.valves = r_q.valve_map[first_idx*8 +: VALVE_W];
          r_d.timer  = r_q.times[15:0];
          r_d.state  = ST_PRESQ;
        end
      end
      ST_PRESQ: begin
        if (!first_held) begin
          r_d.valves = '0;
          r_d.state  = ST_IDLE;
        end else if (r_q.timer == '0) begin
          r_d.timer = r_q.times[31:16];
          r_d.state = ST_SQUEEZE;
        end else begin
          r_d.timer = r_q.timer - 1'b1;
        end
      end
      ST_SQUEEZE: begin
        if (!first_held) begin
          r_d.valves = '0;
          r_d.state  = ST_IDLE;
        end else if (r_q.timer == '0) begin
          r_d.state = ST_WAIT2;
        end else begin
          r_d.timer = r_q.timer - 1'b1;
        end
      end
      ST_WAIT2: begin
        if (!first_held) begin
          r_d.valves = '0;
          r_d.state  = ST_IDLE;
        end else if (second_stage) begin
          r_d.state = ST_PCHECK;
        end
      end
      ST_PCHECK: begin
        // no pressure yet: stay until it rises or the pedal is let go
        if (!first_held) begin
          r_d.valves = '0;
          r_d.state  = ST_IDLE;
        end else if (pressure_switch_input_in) begin
          r_d.start = 1'b1;
          r_d.state = ST_WELD;
        end
      end
      ST_WELD: begin
        if (weld_done_in) begin
          r_d.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (r_q.ctrl[CTRL_REPEAT] && first_held && second_stage) begin
          r_d.timer = r_q.times[15:0];
          r_d.state = ST_PRESQ;
        end else begin
          r_d.valves = '0;
          // wait for release so one press gives one weld
          if (!first_any) begin
            r_d.state = ST_IDLE;
          end
        end
      end
      default: begin
        r_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      r_q.sync1     <= '0;
      r_q.sync2     <= '0;
      r_q.db_cnt    <= '0;
      r_q.clean     <= '0;
      r_q.ctrl      <= CTRL_RESET;
      r_q.times     <= TIMES_RESET;
      r_q.valve_map <= VALVES_RESET;
      r_q.state     <= ST_IDLE;
      r_q.timer     <= '0;
      r_q.sw_idx    <= '0;
      r_q.valves    <= '0;
      r_q.sched     <= '0;
      r_q.start     <= 1'b0;
      r_q.rdata     <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata_out     = r_q.rdata;
  assign weld_start_out = r_q.start;
  assign schedule_out   = r_q.sched;

  // the active switch's valve pattern goes on its own lane
  generate
    for (genvar g = 0; g < N_SW; g++) begin : g_valve
      assign valves_out[g*VALVE_W +: VALVE_W] = (r_q.sw_idx == 2'(g)) ? r_q.valves : '0;
    end
  endgenerate

endmodule : tswi_top
`default_nettype wire

/* File: sim/tswi_pedal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tswi_pedal_model (
  input  wire logic [3:0] pedal_first_in,
  input  wire logic [3:0] pedal_second_in,
  output wire logic [3:0] contacts_out,
  output wire logic       stage2_out
);
  // no contact bounce: the debounce cost is covered by hold times in the bench
  assign contacts_out = pedal_first_in;
  // second limit only closes behind the first, all pedals wired in parallel
  assign stage2_out   = |(pedal_first_in & pedal_second_in);
endmodule : tswi_pedal_model
`default_nettype wire

/* File: sim/tswi_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module tswi_checker
  import tswi_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [3:0]  foot_first_stage_contacts_in,
  input wire logic        pressure_switch_input_in,
  input wire logic        weld_done_in,
  input wire logic [11:0] valves_out,
  input wire logic        weld_start_out,
  input wire logic [6:0]  schedule_out
);
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic        weld_q;
  wire         any_w = |foot_first_stage_contacts_in;
  // saturating run lengths; a weld in flight keeps valves on after release
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hi_q   <= 16'h0000;
      lo_q   <= 16'h0000;
      weld_q <= 1'b0;
    end else begin
      hi_q   <= any_w ? hi_q + {15'h0000, ~&hi_q} : 16'h0000;
      lo_q   <= any_w ? 16'h0000 : lo_q + {15'h0000, ~&lo_q};
      weld_q <= weld_start_out | (weld_q & ~weld_done_in);
    end
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_pready_high: assert property (pready_out) else $error("pready low");
  chk_err_unmapped: assert property (psel_in && penable_in && paddr_in > 32'h0000_000C
    |-> pslverr_out) else $error("unmapped access not refused");
  chk_err_mapped: assert property (psel_in && penable_in && paddr_in <= 32'h0000_000C
    && paddr_in[1:0] == 2'b00 |-> !pslverr_out) else $error("mapped access refused");
  chk_start_pulse: assert property (weld_start_out |=> !weld_start_out)
    else $error("weld start longer than one cycle");
  chk_start_pressure: assert property (weld_start_out |-> $past(pressure_switch_input_in)
    || $past(pressure_switch_input_in, 2) || $past(pressure_switch_input_in, 3))
    else $error("weld start without pressure");
  chk_sched_range: assert property (schedule_out <= 7'h63) else $error("schedule out of range");
  chk_debounce_hold: assert property ($rose(|valves_out) |-> hi_q >= 16'(DEBOUNCE_CYC))
    else $error("valves on before contact settled");
  chk_valves_drop: assert property (lo_q == 16'(DEBOUNCE_CYC + 16) && !weld_q
    |-> valves_out == 12'h000)
    else $error("valves on after release");
  cov_start: cover property (weld_start_out);
  cov_err: cover property (pslverr_out);
  cov_valves: cover property ($rose(|valves_out));
endmodule : tswi_checker
bind tswi_top tswi_checker u_tswi_checker (.clock_in, .rst_n_in, .psel_in, .penable_in,
  .paddr_in, .pready_out, .pslverr_out, .foot_first_stage_contacts_in,
  .pressure_switch_input_in, .weld_done_in, .valves_out, .weld_start_out, .schedule_out);
`default_nettype wire

/* File: sim/tswi_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tswi_top_test;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } tswi_row_t;
  logic        clock_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic        programmable_input_nine_in, pressure_switch_input_in, weld_done_in;
  logic        weld_start_out, err;
  logic [31:0] paddr_in, pwdata_in, prdata_out, rd;
  logic [3:0]  foot_first_stage_contacts_in, first_cmd, second_cmd;
  logic [6:0]  ext_schedule_select_in, schedule_out;
  logic [11:0] valves_out;
  int          fails, compares, n;
  // multi mode, repeat, second stage on input nine from local source, use-page schedule 42
  tswi_row_t   rows [4] = '{'{32'h0, 32'h002A_0913, 32'h002A_0913, 1'b0},
                            '{32'h4, 32'h0003_0002, 32'h0003_0002, 1'b0},
                            '{32'h8, 32'h0000_0305, 32'h0000_0305, 1'b0},
                            '{32'h10, 32'hFFFF_FFFF, 32'h0, 1'b1}};
  tswi_top u_tswi_top (.clock_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .foot_first_stage_contacts_in,
    .programmable_input_nine_in, .pressure_switch_input_in, .ext_schedule_select_in,
    .weld_done_in, .valves_out, .weld_start_out, .schedule_out);
  tswi_pedal_model u_tswi_pedal_model (.pedal_first_in(first_cmd), .pedal_second_in(second_cmd),
    .contacts_out(foot_first_stage_contacts_in), .stage2_out(programmable_input_nine_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic [31:0] a, input logic [31:0] d, input logic w);
    int k;
    @(posedge clock_in);
    psel_in   <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    rd  = prdata_out;
    err = pslverr_out;
    psel_in   <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    #800_000;
    fails++;
    finish_test();
  end
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, weld_done_in} = 5'h00;
    {paddr_in, pwdata_in} = 64'h0;
    {first_cmd, second_cmd} = 8'h00;
    pressure_switch_input_in = 1'b1;
    ext_schedule_select_in = 7'h05;
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    chk({20'h0, valves_out}, 32'h0);
    apb(32'h0, 32'h0, 1'b0);
    chk(rd, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].d, 1'b1);
      chk({31'h0, err}, {31'h0, rows[i].e});
      apb(rows[i].a, 32'h0, 1'b0);
      chk(rd, rows[i].r);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    $display("test registers done");
    // second stage closes together with the first, before either interval runs out
    first_cmd <= 4'h1;
    second_cmd <= 4'h1;
    // outputs are looked at on the falling edge, where they have settled
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (valves_out === 12'h000 && n < 1100);
    chk({20'h0, valves_out}, 32'h5);
    chk({25'h0, schedule_out}, 32'h2A);
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (weld_start_out !== 1'b1 && n < 40);
    // three pre-squeeze, four squeeze, one wait, one pressure check
    chk(32'(n), 32'h9);
    @(posedge clock_in);
    weld_done_in <= 1'b1;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (weld_start_out !== 1'b1 && n < 40);
    chk(32'(n < 40), 32'h1);
    @(posedge clock_in);
    first_cmd <= 4'h0;
    second_cmd <= 4'h0;
    repeat (tswi_pkg::DEBOUNCE_CYC + 20) @(posedge clock_in);
    n = 0;
    repeat (40) begin
      @(negedge clock_in);
      n += int'(weld_start_out === 1'b1);
    end
    chk(32'(n), 32'h0);
    chk({20'h0, valves_out}, 32'h0);
    $display("test weld done");
    @(posedge clock_in);
    first_cmd <= 4'h2;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (valves_out === 12'h000 && n < 1100);
    chk({20'h0, valves_out}, 32'h18);
    chk({25'h0, schedule_out}, 32'h14);
    @(posedge clock_in);
    first_cmd <= 4'h0;
    repeat (tswi_pkg::DEBOUNCE_CYC + 10) @(posedge clock_in);
    chk({20'h0, valves_out}, 32'h0);
    $display("test abandon done");
    finish_test();
  end
endmodule : tswi_top_test
`default_nettype wire
